// ==== logic/fault_mask_and_adc_control.sv ====
// Purpose: fault interrupt mask, converter control and result holding register
// Assumes: register port driven by the serial interface logic on clk; events are one-cycle pulses
// Notes: irq_pulse is a one-cycle active-high pulse; the pin driver inverts it if needed
// Behaviour
// - Input overvoltage or sleep entry pulses the interrupt unless mask bit 7 is set.
// - Battery overcurrent or overvoltage pulses the interrupt unless mask bit 6 is set.
// - System overvoltage or short pulses the interrupt unless mask bit 5 is set.
// - Boost bus or mid-point faults pulse the interrupt unless mask bit 4 is set.
// - Thermal shutdown pulses the interrupt unless mask bit 3 is set.
// - Temperature zone changes pulse the interrupt unless mask bit 0 is set.
// - The result register is zero after reset and then holds the last measurement, or the running average when averaging is on.
// - Converter enable bit 7 defaults off and is cleared by register reset or watchdog.
// - Rate bit 6 selects continuous conversion at 0 and one-shot at 1.
// - Bits 5:4 give resolution 12, 11, 10 or 9 bits, with 9 after reset.
// - Averaging bit 3 selects single values at 0 and a running average at 1.
// - Seed bit 2 starts the average from the held value at 0 or a fresh result at 1.
// - In one-shot mode a finished conversion pulses the interrupt unless its mask is set.
`timescale 1ns/1ps
`default_nettype none

module fault_mask_and_adc_control
    import fault_adc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire fault_adc_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire fault_adc_pkg::fault_events_t fault_events,
    input wire logic conv_done_mask,
    input wire logic conv_done,
    input wire logic [fault_adc_pkg::RESULT_W-1:0] conv_sample,
    output fault_adc_pkg::conv_cfg_t conv_cfg,
    output logic [fault_adc_pkg::RESULT_W-1:0] conv_result,
    output logic conv_one_shot_clear,
    output logic irq_pulse
);
    import fault_adc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] ctrl;
        logic [RESULT_W-1:0] result;
        logic avg_active;
        logic clear_en;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [RESULT_W:0] avg_sum;
    logic fault_hit;
    logic done_hit;

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        avg_sum = {1'b0, s_q.result} + {1'b0, conv_sample};
        fault_hit = (fault_events.input_fault & ~s_q.mask[INPUT_MASK_BIT])
            | ((fault_events.battery_ocp | fault_events.battery_ovp)
               & ~s_q.mask[BATTERY_MASK_BIT])
            | ((fault_events.system_ovp | fault_events.system_short)
               & ~s_q.mask[SYSTEM_MASK_BIT])
            | (fault_events.boost_fault & ~s_q.mask[BOOST_MASK_BIT])
            | (fault_events.thermal_shutdown_event & ~s_q.mask[THERMAL_MASK_BIT])
            | (fault_events.temp_zone_change & ~s_q.mask[ZONE_MASK_BIT]);
        done_hit = conv_done & s_q.ctrl[CONV_EN_BIT] & s_q.ctrl[RATE_BIT] & ~conv_done_mask;
        s_d.irq = fault_hit | done_hit;
        s_d.clear_en = 1'b0;
        if (reg_req.wr && reg_req.addr == FAULT_MASK_ADDR) begin
            s_d.mask = reg_req.wdata & FAULT_MASK_WMASK;
        end
        if (reg_req.wr && reg_req.addr == CONV_CTRL_ADDR) begin
            s_d.ctrl = reg_req.wdata & CONV_CTRL_WMASK;
        end
        // one-shot pass finishes: converter turns itself off
        if (conv_done && s_q.ctrl[CONV_EN_BIT] && s_q.ctrl[RATE_BIT]) begin
            s_d.ctrl[CONV_EN_BIT] = 1'b0;
            s_d.clear_en = 1'b1;
        end
        // the average is re-seeded every time averaging is switched on again
        if (!s_q.ctrl[AVG_BIT]) begin
            s_d.avg_active = 1'b0;
        end
        if (conv_done && s_q.ctrl[CONV_EN_BIT]) begin
            if (!s_q.ctrl[AVG_BIT]) begin
                s_d.result = conv_sample;
            end else if (!s_q.avg_active && s_q.ctrl[SEED_BIT]) begin
                s_d.result = conv_sample;
                s_d.avg_active = 1'b1;
            end else begin
                s_d.result = avg_sum[RESULT_W:1];
                s_d.avg_active = 1'b1;
            end
        end
        // register reset and watchdog come last so they win over a same-cycle write
        if (reg_reset) begin
            s_d.mask = FAULT_MASK_RESET;
            s_d.ctrl = CONV_CTRL_RESET;
            s_d.avg_active = 1'b0;
        end
        if (watchdog_expired) begin
            s_d.ctrl[CONV_EN_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.ctrl <= CONV_CTRL_RESET;
            s_q.result <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        case (reg_req.addr)
            FAULT_MASK_ADDR: reg_rdata = s_q.mask & FAULT_MASK_WMASK;
            CONV_CTRL_ADDR: reg_rdata = s_q.ctrl & CONV_CTRL_WMASK;
            default: reg_rdata = 8'h00;
        endcase
    end

    always_comb begin
        conv_cfg.enable = s_q.ctrl[CONV_EN_BIT];
        conv_cfg.rate = s_q.ctrl[RATE_BIT] ? MODE_ONE_SHOT : MODE_CONTINUOUS;
        conv_cfg.resolution_bits = RES_BITS_BASE
            - {2'b00, s_q.ctrl[RES_HI_BIT:RES_LO_BIT]};
        conv_cfg.averaging_enable = s_q.ctrl[AVG_BIT];
        conv_cfg.average_seed_select = s_q.ctrl[SEED_BIT];
    end

    assign conv_result = s_q.result;
    assign conv_one_shot_clear = s_q.clear_en;
    assign irq_pulse = s_q.irq;

    // ==========================================================
    // checks
    sequence input_fault_seen;
        fault_events.input_fault && !s_q.mask[INPUT_MASK_BIT];
    endsequence

    sequence one_shot_done;
        conv_done && conv_cfg.enable && conv_cfg.rate == MODE_ONE_SHOT;
    endsequence

    sequence one_shot_end;
        !conv_cfg.enable && conv_one_shot_clear;
    endsequence

    sequence avg_done;
        conv_done && s_q.ctrl[CONV_EN_BIT] && s_q.ctrl[AVG_BIT];
    endsequence

    sequence avg_first_done;
        avg_done ##0 !s_q.avg_active;
    endsequence

    input_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        input_fault_seen |=> irq_pulse) else $error("input fault lost");
    battery_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fault_events.battery_ocp || fault_events.battery_ovp) && !s_q.mask[BATTERY_MASK_BIT]
        |=> irq_pulse) else $error("battery fault lost");
    system_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fault_events.system_ovp || fault_events.system_short) && !s_q.mask[SYSTEM_MASK_BIT]
        |=> irq_pulse) else $error("system fault lost");
    boost_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        fault_events.boost_fault && !s_q.mask[BOOST_MASK_BIT] |=> irq_pulse)
        else $error("boost fault lost");
    thermal_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        fault_events.thermal_shutdown_event && !s_q.mask[THERMAL_MASK_BIT] |=> irq_pulse)
        else $error("thermal fault lost");
    zone_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        fault_events.temp_zone_change && !s_q.mask[ZONE_MASK_BIT] |=> irq_pulse)
        else $error("zone change lost");
    masked_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        (&s_q.mask[7:3]) && s_q.mask[0] && !done_hit |=> !irq_pulse)
        else $error("masked event raised interrupt");
    result_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(conv_done && s_q.ctrl[CONV_EN_BIT]) |=> $stable(conv_result))
        else $error("result changed without conversion");
    wdog_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
        watchdog_expired |=> !conv_cfg.enable) else $error("enable survived watchdog");
    reset_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_reset |=> s_q.mask == FAULT_MASK_RESET && s_q.ctrl == CONV_CTRL_RESET)
        else $error("register reset lost");
    // a continuous pass keeps the converter on unless something else turns it off
    cont_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        conv_done && conv_cfg.enable && conv_cfg.rate == MODE_CONTINUOUS && !reg_reset
        && !watchdog_expired && !(reg_req.wr && reg_req.addr == CONV_CTRL_ADDR)
        |=> conv_cfg.enable) else $error("continuous mode stopped");
    one_shot_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        one_shot_done |=> one_shot_end) else $error("one-shot pass did not stop");
    res_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_reset |=> conv_cfg.resolution_bits == 4'h9) else $error("resolution reset wrong");
    res_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        conv_cfg.resolution_bits >= 4'h9 && conv_cfg.resolution_bits <= 4'hC)
        else $error("resolution out of range");
    single_value_a: assert property (@(posedge clk) disable iff (sys_rst)
        conv_done && s_q.ctrl[CONV_EN_BIT] && !s_q.ctrl[AVG_BIT]
        |=> conv_result == $past(conv_sample)) else $error("single value not taken");
    seed_fresh_a: assert property (@(posedge clk) disable iff (sys_rst)
        avg_first_done ##0 s_q.ctrl[SEED_BIT]
        |=> conv_result == $past(conv_sample)) else $error("fresh seed not taken");
    running_avg_a: assert property (@(posedge clk) disable iff (sys_rst)
        avg_done ##0 (s_q.avg_active || !s_q.ctrl[SEED_BIT])
        |=> conv_result == RESULT_W'(({1'b0, $past(conv_result)}
        + {1'b0, $past(conv_sample)}) >> 1)) else $error("running average wrong");
    done_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
        one_shot_done ##0 !conv_done_mask |=> irq_pulse ##0 one_shot_end)
        else $error("done pulse missing");
    done_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
        one_shot_done ##0 (conv_done_mask && !fault_hit) |=> !irq_pulse)
        else $error("masked done raised interrupt");
    reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        !((reg_req.addr == FAULT_MASK_ADDR && reg_rdata[2:1] != 2'b00)
        || (reg_req.addr == CONV_CTRL_ADDR && reg_rdata[1:0] != 2'b00)))
        else $error("reserved bits nonzero");
endmodule

`default_nettype wire

// ==== logic/fault_adc_pkg.sv ====
// Purpose: constants and carriers for the fault mask and converter control slice
// Assumes: 8-bit registers reached over a byte-wide register port
// Notes: offsets are the register addresses of the serial interface
package fault_adc_pkg;
    localparam logic [7:0] FAULT_MASK_ADDR = 8'h25;
    localparam logic [7:0] CONV_CTRL_ADDR = 8'h26;
    localparam logic [7:0] FAULT_MASK_RESET = 8'h00;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h30;
    localparam logic [7:0] FAULT_MASK_WMASK = 8'hF9;
    localparam logic [7:0] CONV_CTRL_WMASK = 8'hFC;
    localparam int INPUT_MASK_BIT = 7;
    localparam int BATTERY_MASK_BIT = 6;
    localparam int SYSTEM_MASK_BIT = 5;
    localparam int BOOST_MASK_BIT = 4;
    localparam int THERMAL_MASK_BIT = 3;
    localparam int ZONE_MASK_BIT = 0;
    localparam int CONV_EN_BIT = 7;
    localparam int RATE_BIT = 6;
    localparam int RES_HI_BIT = 5;
    localparam int RES_LO_BIT = 4;
    localparam int AVG_BIT = 3;
    localparam int SEED_BIT = 2;
    localparam logic [3:0] RES_BITS_BASE = 4'hC;
    localparam int RESULT_W = 16;

    typedef enum logic {MODE_CONTINUOUS, MODE_ONE_SHOT} rate_mode_t;

    typedef struct packed {
        logic input_fault;
        logic battery_ocp;
        logic battery_ovp;
        logic system_ovp;
        logic system_short;
        logic boost_fault;
        logic thermal_shutdown_event;
        logic temp_zone_change;
    } fault_events_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic enable;
        rate_mode_t rate;
        logic [3:0] resolution_bits;
        logic averaging_enable;
        logic average_seed_select;
    } conv_cfg_t;
endpackage

// ==== verif/host_model.sv ====
// Purpose: host side of the register port, byte writes and reads
// Assumes: reads are combinational, so data is sampled mid-cycle
// Notes: write strobe lasts one cycle
`timescale 1ns/1ps
`default_nettype none
module host_model
    import fault_adc_pkg::*;
(
    input wire logic clk,
    output fault_adc_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    initial reg_req = '0;
    // ========
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b0, a, 8'hA5};
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the fault mask and converter control slice
// Assumes: registers are reached only through host_model
// Notes: random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fault_adc_pkg::*;
    logic clk = 0, sys_rst = 1, reg_reset = 0, watchdog_expired = 0;
    logic conv_done_mask = 0, conv_done = 0, conv_one_shot_clear, irq_pulse, irq_seen, clr_seen;
    logic [7:0] reg_rdata, rv, m;
    logic [15:0] conv_sample = 16'h0000, conv_result, r;
    logic [31:0] seed = 32'd68146;
    reg_req_t reg_req;
    fault_events_t fault_events = '0;
    conv_cfg_t conv_cfg;
    int mismatches = 0, total_checks = 0;
    fault_mask_and_adc_control fault_mask_and_adc_control_inst (.clk(clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_reset(reg_reset),
        .watchdog_expired(watchdog_expired), .fault_events(fault_events),
        .conv_done_mask(conv_done_mask), .conv_done(conv_done), .conv_sample(conv_sample),
        .conv_cfg(conv_cfg), .conv_result(conv_result),
        .conv_one_shot_clear(conv_one_shot_clear), .irq_pulse(irq_pulse));
    host_model host_model_inst (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    always #5 clk = ~clk;
    // ========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int mbit(input int i);
        return i == 0 ? 7 : i < 3 ? 6 : i < 5 ? 5 : i == 5 ? 4 : i == 6 ? 3 : 0;
    endfunction
    function automatic logic [15:0] avg(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16:1];
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.rd(a, rv);
        chk({8'h00, rv}, {8'h00, e});
    endtask
    task automatic conv(input logic [15:0] s);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_sample <= s;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_sample <= ~s;
        @(negedge clk);
        irq_seen = irq_pulse;
        clr_seen = conv_one_shot_clear;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    // ========
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(8'h25, 8'h00);
        rchk(8'h26, 8'h30);
        chk({12'h000, conv_cfg.resolution_bits}, 16'd9);
        chk(conv_result, 16'h0000);
        host_model_inst.wr(8'h25, 8'hFF);
        rchk(8'h25, 8'hF9);
        host_model_inst.wr(8'h26, 8'hFF);
        rchk(8'h26, 8'hFC);
        @(posedge clk) reg_reset <= 1'b1;
        @(posedge clk) reg_reset <= 1'b0;
        rchk(8'h26, 8'h30);
        rchk(8'h25, 8'h00);
        host_model_inst.wr(8'h27, 8'hFF);
        rchk(8'h27, 8'h00);
        rchk(8'h26, 8'h30);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            host_model_inst.wr(8'h26, 8'(c << 4));
            @(negedge clk);
            chk({12'h000, conv_cfg.resolution_bits}, 16'(12 - c));
        end
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            m = (k < 8) ? 8'h00 : (k < 16) ? 8'hFF : seed[7:0];
            host_model_inst.wr(8'h25, m);
            @(posedge clk) fault_events <= 8'h80 >> (k % 8);
            @(posedge clk) fault_events <= '0;
            @(negedge clk) chk({15'h0, irq_pulse}, {15'h0, !m[mbit(k % 8)]});
        end
        $display("test masks done");
        host_model_inst.wr(8'h26, 8'h80);
        conv(seed[15:0]);
        chk(conv_result, seed[15:0]);
        chk({15'h0, irq_seen}, 16'h0000);
        chk({15'h0, clr_seen}, 16'h0000);
        chk({15'h0, conv_cfg.enable}, 16'h0001);
        host_model_inst.wr(8'h26, 8'h00);
        conv(16'h1234);
        chk(conv_result, seed[15:0]);
        for (int s = 0; s < 2; s++) begin
            r = conv_result;
            host_model_inst.wr(8'h26, 8'h80);
            host_model_inst.wr(8'h26, 8'(8'h88 | (s << 2)));
            seed = lfsr(seed);
            conv(seed[15:0]);
            chk(conv_result, s ? seed[15:0] : avg(r, seed[15:0]));
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) conv_done_mask <= k[0];
            host_model_inst.wr(8'h26, 8'hC0);
            conv(16'hBEEF);
            chk({15'h0, irq_seen}, {15'h0, !k[0]});
            chk({15'h0, conv_cfg.enable}, 16'h0000);
            chk({15'h0, clr_seen}, 16'h0001);
        end
        host_model_inst.wr(8'h26, 8'h80);
        @(posedge clk) watchdog_expired <= 1'b1;
        @(posedge clk) watchdog_expired <= 1'b0;
        rchk(8'h26, 8'h00);
        $display("test converter done");
        @(posedge clk) sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk) chk(conv_result, 16'h0000);
        rchk(8'h26, 8'h30);
        rchk(8'h25, 8'h00);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
